// >>> rtl/ccc_pkg.sv
package ccc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CHOP = 8'h00;
  localparam logic [7:0] OFS_CURR = 8'h04;
  localparam logic [7:0] OFS_PWDN = 8'h08;
  localparam logic [7:0] OFS_DRV = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  // chopper control fields
  localparam int FDT_POS = 0;
  localparam int FDT_W = 4;
  localparam int SOFS_POS = 4;
  localparam int SOFS_W = 4;
  localparam int MODE_POS = 8;
  localparam int DISCMP_POS = 9;
  // current control fields
  localparam int HOLD_CS_POS = 0;
  localparam int RUN_CS_POS = 8;
  localparam int IHDLY_POS = 16;
  localparam int IRDLY_POS = 24;
  localparam int CS_W = 5;
  localparam int DLY_W = 4;
  // power-down fields
  localparam int TPD_POS = 0;
  localparam int ZW_POS = 8;
  localparam int PD_W = 8;
  // driver fields
  localparam int IREF_POS = 0;
  localparam int IREF_W = 2;
  // status fields
  localparam int ST_CS_POS = 0;
  localparam int ST_FSM_POS = 8;
  localparam int ST_FD_POS = 12;
  // reset values
  localparam logic [31:0] CHOP_RST = 32'h0000_0025;
  localparam logic [31:0] CURR_RST = 32'h0401_1F08;
  localparam logic [31:0] PWDN_RST = 32'h0000_000A;
  localparam logic [31:0] DRV_RST = 32'h0000_0000;
  // offset decode: field value minus three
  localparam logic [4:0] SOFS_BIAS = 5'h03;
  // timing counts in system clocks
  localparam int FD_UNIT_CYC = 32;
  localparam int RUN_UNIT_CYC = 512;
  localparam int ZW_UNIT_CYC = 512;
  localparam int HOLD_UNIT_CYC = 262144;
  localparam int PD_UNIT_CYC = 262144;
  localparam int UNIT_W = 19;
  // reference current percentages
  localparam logic [6:0] IREF_PCT0 = 7'h19;
  localparam logic [6:0] IREF_PCT1 = 7'h32;
  localparam logic [6:0] IREF_PCT2 = 7'h4B;
  localparam logic [6:0] IREF_PCT3 = 7'h64;
  // current ramp states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STST = 3'b001,
    ST_ZWAIT = 3'b010,
    ST_HRAMP = 3'b011,
    ST_HOLD = 3'b100,
    ST_RRAMP = 3'b101
  } ccc_state_t;
endpackage

// >>> rtl/ccc_delay.sv
// counts mult units of unit clocks, one-cycle done pulse
module ccc_delay (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic restart,
  input wire logic [7:0] mult,
  input wire logic [ccc_pkg::UNIT_W-1:0] unit,
  // result
  output logic done
);
  logic [ccc_pkg::UNIT_W-1:0] pre_r;
  logic [7:0] units_r;
  logic fired_r;

  // fires once when the unit count reaches mult; not gated by restart,
  // which depends on done through the ramp state and would close a loop
  assign done = !fired_r && (units_r == mult);

  // prescaler and unit counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= '0;
      units_r <= '0;
      fired_r <= 1'b1;
    end else if (restart) begin
      pre_r <= '0;
      units_r <= '0;
      fired_r <= 1'b0;
    end else if (done) begin
      fired_r <= 1'b1;
    end else if (!fired_r) begin
      if (pre_r == unit - 1'b1) begin
        pre_r <= '0;
        units_r <= units_r + 8'h01;
      end else begin
        pre_r <= pre_r + 1'b1;
      end
    end
  end
endmodule

// >>> rtl/ccc_fd_timer.sv
// fast-decay phase timer of the constant off-time chopper
module ccc_fd_timer (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic enable,
  input wire logic on_phase_end,
  input wire logic [3:0] fd_time,
  input wire logic cmp_enable,
  input wire logic neg_exceeds_pos,
  // result
  output logic fd_active
);
  localparam logic [8:0] UNIT = 9'(ccc_pkg::FD_UNIT_CYC);
  logic [8:0] cnt_r;
  logic [8:0] len;

  assign len = 9'(fd_time * UNIT);

  // start on each on-phase end with nonzero fd_time, stop on time or comparator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fd_active <= 1'b0;
      cnt_r <= '0;
    end else if (!enable) begin
      fd_active <= 1'b0;
      cnt_r <= '0;
    end else if (on_phase_end && fd_time != 4'h0) begin
      fd_active <= 1'b1;
      cnt_r <= 9'h001;
    end else if (fd_active) begin
      if (cmp_enable && neg_exceeds_pos) begin
        fd_active <= 1'b0;
      end else if (cnt_r >= len) begin
        fd_active <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 9'h001;
      end
    end
  end
endmodule

// >>> rtl/ccc_top.sv
// What this block does
// - in off-time mode, fast-decay length follows fast_decay_time; zero means slow only.
// - in off-time mode, sine offset is hyst_end_field minus three.
// - comparator ends fast decay early unless disabled; then time only.
// - while moving, sine values scale by run_current_scale plus one over 32.
// - adaptive load-dependent scale is capped at the run scale.
// - at standstill the hold scale applies, same encoding as run.
// - hold ramp delay zero drops instantly, else delay times 2^18 per step.
// - stepwise reduction toward hold starts only after zero wait time.
// - motion start ramps up one step per run delay times 512 clocks.
// - run ramp delay zero jumps straight to run scale.
// - power-down waits standstill delay times 2^18 clocks after standstill.
// - reference scale 0..3 gives 25, 50, 75, 100 percent.
module ccc_top #(
  parameter int HOLD_UNIT_CYC = ccc_pkg::HOLD_UNIT_CYC,
  parameter int PD_UNIT_CYC = ccc_pkg::PD_UNIT_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // motion and load inputs
  input wire logic standstill,
  input wire logic [4:0] adaptive_scale,
  // chopper inputs
  input wire logic on_phase_end,
  input wire logic neg_exceeds_pos,
  // sine table values per phase
  input wire logic signed [8:0] coil_a_sine,
  input wire logic signed [8:0] coil_b_sine,
  // chopper outputs
  output logic chopper_mode_select,
  output logic fast_decay_active,
  output logic signed [4:0] sine_offset,
  // current outputs
  output logic [4:0] current_scale,
  output logic signed [8:0] coil_a_target,
  output logic signed [8:0] coil_b_target,
  output logic [1:0] reference_current_scale,
  output logic [6:0] iref_percent
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and bus

  logic [31:0] chop_r;
  logic [31:0] curr_r;
  logic [31:0] pwdn_r;
  logic [31:0] drv_r;
  logic [31:0] status;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic addr_ok;
  logic [31:0] rd_nxt;
  ccc_pkg::ccc_state_t state_r;
  ccc_pkg::ccc_state_t state_nxt;
  logic [4:0] cs_r;
  logic [4:0] cs_nxt;

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && htrans[1];

  // status word from live state
  always_comb begin
    status = '0;
    status[ccc_pkg::ST_CS_POS +: ccc_pkg::CS_W] = cs_r;
    status[ccc_pkg::ST_FSM_POS +: 3] = state_r;
    status[ccc_pkg::ST_FD_POS] = fast_decay_active;
  end

  // read mux, unmapped reads as zero
  always_comb begin
    case (haddr[7:0])
      ccc_pkg::OFS_CHOP: rd_nxt = chop_r;
      ccc_pkg::OFS_CURR: rd_nxt = curr_r;
      ccc_pkg::OFS_PWDN: rd_nxt = pwdn_r;
      ccc_pkg::OFS_DRV: rd_nxt = drv_r;
      ccc_pkg::OFS_STAT: rd_nxt = status;
      default: rd_nxt = '0;
    endcase
  end

  // capture address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata <= '0;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_r <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  // register writes in data phase, only defined bits kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chop_r <= ccc_pkg::CHOP_RST;
      curr_r <= ccc_pkg::CURR_RST;
      pwdn_r <= ccc_pkg::PWDN_RST;
      drv_r <= ccc_pkg::DRV_RST;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        ccc_pkg::OFS_CHOP: chop_r <= hwdata & 32'h0000_03FF;
        ccc_pkg::OFS_CURR: curr_r <= hwdata & 32'h0F0F_1F1F;
        ccc_pkg::OFS_PWDN: pwdn_r <= hwdata & 32'h0000_FFFF;
        ccc_pkg::OFS_DRV: drv_r <= hwdata & 32'h0000_0003;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field views

  logic [3:0] fd_time;
  logic [3:0] sofs;
  logic mode_sel;
  logic cmp_dis;
  logic [4:0] run_cs;
  logic [4:0] hold_cs;
  logic [3:0] hdly;
  logic [3:0] rdly;
  logic [7:0] tpd;
  logic [7:0] zwait;

  assign fd_time = chop_r[ccc_pkg::FDT_POS +: ccc_pkg::FDT_W];
  assign sofs = chop_r[ccc_pkg::SOFS_POS +: ccc_pkg::SOFS_W];
  assign mode_sel = chop_r[ccc_pkg::MODE_POS];
  assign cmp_dis = chop_r[ccc_pkg::DISCMP_POS];
  assign run_cs = curr_r[ccc_pkg::RUN_CS_POS +: ccc_pkg::CS_W];
  assign hold_cs = curr_r[ccc_pkg::HOLD_CS_POS +: ccc_pkg::CS_W];
  assign hdly = curr_r[ccc_pkg::IHDLY_POS +: ccc_pkg::DLY_W];
  assign rdly = curr_r[ccc_pkg::IRDLY_POS +: ccc_pkg::DLY_W];
  assign tpd = pwdn_r[ccc_pkg::TPD_POS +: ccc_pkg::PD_W];
  assign zwait = pwdn_r[ccc_pkg::ZW_POS +: ccc_pkg::PD_W];

  ////////////////////////////////////////////////////////////////////////////
  // constant off-time chopper

  ccc_fd_timer u_fd (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(mode_sel),
    .on_phase_end(on_phase_end),
    .fd_time(fd_time),
    .cmp_enable(!cmp_dis),
    .neg_exceeds_pos(neg_exceeds_pos),
    .fd_active(fast_decay_active)
  );

  // decoded sine offset, zero outside off-time mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sine_offset <= '0;
      chopper_mode_select <= 1'b0;
    end else begin
      chopper_mode_select <= mode_sel;
      if (mode_sel) begin
        sine_offset <= $signed({1'b0, sofs} - ccc_pkg::SOFS_BIAS);
      end else begin
        sine_offset <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold / run current ramp

  logic dly_restart;
  logic dly_done;
  logic step;
  logic [7:0] dly_mult;
  logic [ccc_pkg::UNIT_W-1:0] dly_unit;

  // delay length chosen by phase of the ramp
  always_comb begin
    case (state_r)
      ccc_pkg::ST_STST: begin
        dly_mult = tpd;
        dly_unit = ccc_pkg::UNIT_W'(PD_UNIT_CYC);
      end
      ccc_pkg::ST_ZWAIT: begin
        dly_mult = zwait;
        dly_unit = ccc_pkg::UNIT_W'(ccc_pkg::ZW_UNIT_CYC);
      end
      ccc_pkg::ST_HRAMP: begin
        dly_mult = {4'h0, hdly};
        dly_unit = ccc_pkg::UNIT_W'(HOLD_UNIT_CYC);
      end
      ccc_pkg::ST_RRAMP: begin
        dly_mult = {4'h0, rdly};
        dly_unit = ccc_pkg::UNIT_W'(ccc_pkg::RUN_UNIT_CYC);
      end
      default: begin
        dly_mult = '0;
        dly_unit = ccc_pkg::UNIT_W'(1);
      end
    endcase
  end

  // restart on every state change and every step
  assign dly_restart = (state_nxt != state_r) || step;

  ccc_delay u_dly (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(dly_restart),
    .mult(dly_mult),
    .unit(dly_unit),
    .done(dly_done)
  );

  // next ramp state and scale
  always_comb begin
    state_nxt = state_r;
    cs_nxt = cs_r;
    step = 1'b0;
    case (state_r)
      ccc_pkg::ST_RUN: begin
        cs_nxt = run_cs;
        if (standstill) begin
          state_nxt = ccc_pkg::ST_STST;
        end
      end
      ccc_pkg::ST_STST: begin
        if (!standstill) begin
          state_nxt = ccc_pkg::ST_RUN;
        end else if (dly_done) begin
          state_nxt = ccc_pkg::ST_ZWAIT;
        end
      end
      ccc_pkg::ST_ZWAIT: begin
        if (!standstill) begin
          state_nxt = ccc_pkg::ST_RUN;
        end else if (dly_done) begin
          if (hdly == 4'h0 || cs_r <= hold_cs) begin
            cs_nxt = hold_cs;
            state_nxt = ccc_pkg::ST_HOLD;
          end else begin
            state_nxt = ccc_pkg::ST_HRAMP;
          end
        end
      end
      ccc_pkg::ST_HRAMP: begin
        if (!standstill) begin
          if (rdly == 4'h0) begin
            cs_nxt = run_cs;
            state_nxt = ccc_pkg::ST_RUN;
          end else begin
            state_nxt = ccc_pkg::ST_RRAMP;
          end
        end else if (cs_r <= hold_cs) begin
          cs_nxt = hold_cs;
          state_nxt = ccc_pkg::ST_HOLD;
        end else if (dly_done) begin
          cs_nxt = cs_r - 5'h01;
          step = 1'b1;
          if (cs_r - 5'h01 <= hold_cs) begin
            state_nxt = ccc_pkg::ST_HOLD;
          end
        end
      end
      ccc_pkg::ST_HOLD: begin
        cs_nxt = hold_cs;
        if (!standstill) begin
          if (rdly == 4'h0) begin
            cs_nxt = run_cs;
            state_nxt = ccc_pkg::ST_RUN;
          end else begin
            state_nxt = ccc_pkg::ST_RRAMP;
          end
        end
      end
      ccc_pkg::ST_RRAMP: begin
        if (standstill) begin
          state_nxt = ccc_pkg::ST_STST;
        end else if (rdly == 4'h0 || cs_r >= run_cs) begin
          cs_nxt = run_cs;
          state_nxt = ccc_pkg::ST_RUN;
        end else if (dly_done) begin
          cs_nxt = cs_r + 5'h01;
          step = 1'b1;
          if (cs_r + 5'h01 >= run_cs) begin
            state_nxt = ccc_pkg::ST_RUN;
          end
        end
      end
      default: begin
        state_nxt = ccc_pkg::ST_RUN;
        cs_nxt = run_cs;
      end
    endcase
  end

  // ramp state and current scale
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ccc_pkg::ST_RUN;
      cs_r <= ccc_pkg::CURR_RST[ccc_pkg::RUN_CS_POS +: ccc_pkg::CS_W];
    end else begin
      state_r <= state_nxt;
      cs_r <= cs_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // coil current scaling

  logic [4:0] eff_scale;
  logic signed [8:0] sine_in [2];
  logic signed [8:0] target_r [2];

  // adaptive reduction never exceeds run scale while running
  always_comb begin
    if (state_r == ccc_pkg::ST_RUN && adaptive_scale < cs_r) begin
      eff_scale = adaptive_scale;
    end else begin
      eff_scale = cs_r;
    end
  end

  assign sine_in[0] = coil_a_sine;
  assign sine_in[1] = coil_b_sine;

  // per phase: sine times (scale + 1) / 32
  for (genvar p = 0; p < 2; p++) begin : g_phase
    logic signed [15:0] prod;
    assign prod = sine_in[p] * $signed({2'b00, eff_scale} + 7'sd1);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        target_r[p] <= '0;
      end else begin
        target_r[p] <= prod[13:5];
      end
    end
  end

  assign coil_a_target = target_r[0];
  assign coil_b_target = target_r[1];

  // registered scale view
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      current_scale <= '0;
    end else begin
      current_scale <= eff_scale;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference current scaling

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reference_current_scale <= '0;
      iref_percent <= ccc_pkg::IREF_PCT0;
    end else begin
      reference_current_scale <= drv_r[ccc_pkg::IREF_POS +: ccc_pkg::IREF_W];
      case (drv_r[ccc_pkg::IREF_POS +: ccc_pkg::IREF_W])
        2'b00: iref_percent <= ccc_pkg::IREF_PCT0;
        2'b01: iref_percent <= ccc_pkg::IREF_PCT1;
        2'b10: iref_percent <= ccc_pkg::IREF_PCT2;
        default: iref_percent <= ccc_pkg::IREF_PCT3;
      endcase
    end
  end

endmodule

// >>> testbench/ccc_props.sv
// bus, chopper and scaling relations seen at the top ports
module ccc_props #(
  parameter int HOLD_UNIT_CYC = 16,
  parameter int PD_UNIT_CYC = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // chopper
  input wire logic on_phase_end,
  input wire logic chopper_mode_select,
  input wire logic fast_decay_active,
  input wire logic signed [4:0] sine_offset,
  // current
  input wire logic [4:0] current_scale,
  input wire logic signed [8:0] coil_a_sine,
  input wire logic signed [8:0] coil_a_target,
  input wire logic [1:0] reference_current_scale,
  input wire logic [6:0] iref_percent
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take;
  logic [8:0] fd_cnt_r;
  // read address phase taken
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  // fast decay cycles since the last phase end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fd_cnt_r <= 9'h000;
    end else begin
      fd_cnt_r <= (on_phase_end || !fast_decay_active) ? 9'h000 : fd_cnt_r + 9'h001;
    end
  end
  // coil target for a sine value and scale field, floor of product over 32
  function automatic logic signed [8:0] scaled(logic signed [8:0] s, logic [4:0] c);
    logic signed [15:0] p;
    p = 16'(s) * 16'(c + 6'h01);
    return p[13:5];
  endfunction
  ////////////////////////////////////////
  hready_one_a: assert property (hreadyout)
    else $error("bus not ready");
  resp_okay_a: assert property (!hresp)
    else $error("error response");
  unmap_zero_a: assert property (rd_take && haddr[7:0] > 8'h13 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved");
  iref_map_a: assert property ($stable(reference_current_scale) |->
      iref_percent == 7'h19 * (7'(reference_current_scale) + 7'h01))
    else $error("reference percent wrong");
  fd_idle_a: assert property (!chopper_mode_select && !$past(chopper_mode_select)
      |-> !fast_decay_active)
    else $error("fast decay outside mode");
  fd_start_a: assert property ($rose(fast_decay_active) |-> $past(on_phase_end))
    else $error("fast decay without phase end");
  fd_len_a: assert property (fd_cnt_r <= 9'h1E1)
    else $error("fast decay too long");
  offs_off_a: assert property (!chopper_mode_select && !$past(chopper_mode_select)
      |-> sine_offset == 5'h00)
    else $error("offset outside mode");
  tgt_scale_a: assert property ($stable(coil_a_sine) && $stable(current_scale) |=>
      (current_scale == $past(current_scale)
      |-> coil_a_target == scaled($past(coil_a_sine), current_scale)))
    else $error("coil target wrong");
  fd_seen_c: cover property ($rose(fast_decay_active));
  scale_down_c: cover property (current_scale < $past(current_scale));
  iref_full_c: cover property (iref_percent == 7'h64);
endmodule

// >>> testbench/ccc_coil.sv
// coil and bridge stand-in: phase ends and comparator trips
module ccc_coil #(
  parameter int PERIOD = 600,
  parameter int TRIP = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench control
  input wire logic run,
  input wire logic trip_en,
  // bridge side
  input wire logic fd_active,
  output logic on_phase_end,
  output logic neg_exceeds_pos
);
  int per_r;
  int fd_r;
  // on phase ends once per period while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_r <= 0;
      on_phase_end <= 1'b0;
    end else begin
      per_r <= (per_r >= PERIOD - 1 || !run) ? 0 : per_r + 1;
      on_phase_end <= run && per_r == PERIOD - 1;
    end
  end
  // negative current grows during fast decay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fd_r <= 0;
    end else begin
      fd_r <= fd_active ? fd_r + 1 : 0;
    end
  end
  assign neg_exceeds_pos = trip_en && fd_active && fd_r >= TRIP;
endmodule

// >>> testbench/tb_chopper_current_control.sv
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
// self-checking bench for the chopper and current control block
module tb_chopper_current_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UNIT = 16;
  logic hclk, hresetn, hsel, hwrite, standstill, run, trip_en;
  logic hreadyout, hresp, on_phase_end, neg_exceeds_pos;
  logic chopper_mode_select, fast_decay_active;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, reference_current_scale;
  logic [2:0] hsize;
  logic [4:0] adaptive_scale, current_scale;
  logic signed [8:0] coil_a_sine, coil_b_sine, coil_a_target, coil_b_target;
  logic signed [4:0] sine_offset;
  logic [6:0] iref_percent;
  logic [31:0] shadow [4];
  logic [31:0] fd_cfg [7];
  int fd_lo [7], fd_hi [7];
  int miscompares, checks, seed, n, sa, sb, sc, cyc;
  wire hready;
  assign hready = hreadyout;
  ccc_top #(.HOLD_UNIT_CYC(UNIT), .PD_UNIT_CYC(UNIT)) dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .standstill, .adaptive_scale, .on_phase_end,
    .neg_exceeds_pos, .coil_a_sine, .coil_b_sine, .chopper_mode_select,
    .fast_decay_active, .sine_offset, .current_scale, .coil_a_target, .coil_b_target,
    .reference_current_scale, .iref_percent
  );
  ccc_coil coil_u (
    .hclk, .hresetn, .run, .trip_en, .fd_active(fast_decay_active), .on_phase_end,
    .neg_exceeds_pos
  );
  // 200 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // verdict and stop
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // next edge with hready high, bounded
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask
  // single word transfer, read data into rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= 32'(a);
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // write and keep the masked register model
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] m [4] = '{32'h0000_03FF, 32'h0F0F_1F1F, 32'h0000_FFFF, 32'h0000_0003};
    bus(1'b1, a, d);
    if (a < 8'h10) shadow[a[3:2]] = d & m[a[3:2]];
  endtask
  // fast decay cycles in a window holding one phase end
  task automatic fd_count(input logic [31:0] chop, output int len);
    wr(8'h00, chop);
    run <= 1'b1;
    len = 0;
    repeat (1150) begin
      @(posedge hclk);
      len += (fast_decay_active === 1'b1);
    end
    run <= 1'b0;
  endtask
  // cycles until the scale output moves, bounded
  task automatic wait_chg(output int c);
    logic [4:0] old;
    old = current_scale;
    c = 0;
    do begin
      @(posedge hclk);
      c++;
    end while (current_scale === old && c < 3000);
    if (c >= 3000) begin
      miscompares++;
      end_sim();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    seed = 32'h9ca2_64d6;
    hresetn = 1'b0;
    {hsel, hwrite, standstill, run, trip_en} = 5'h00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'b00;
    hsize = 3'b010;
    adaptive_scale = 5'h1F;
    coil_a_sine = 9'h000;
    coil_b_sine = 9'h000;
    shadow = '{32'h0000_0025, 32'h0401_1F08, 32'h0000_000A, 32'h0000_0000};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, then all ones: reserved and unmapped read zero
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        if (i != 4) begin
          if (p == 1) wr(8'(i * 4), 32'hFFFF_FFFF);
          bus(1'b0, 8'(i * 4), 32'h0000_0000);
          `CHK("reg", (i < 4) ? shadow[i] : 32'h0000_0000, rd)
        end
      end
    end
    // every reference scale
    for (int i = 0; i < 4; i++) begin
      wr(8'h0C, 32'(i));
      repeat (2) @(posedge hclk);
      `CHK("iref", 7'(25 * (i + 1)), iref_percent)
    end
    // every offset setting in off-time mode
    for (int h = 0; h < 16; h++) begin
      wr(8'h00, 32'h0000_0102 + 32'(h * 16));
      repeat (2) @(posedge hclk);
      `CHK("offset", 5'(h - 3), sine_offset)
    end
    // fast decay: min, max, random, mode off, slow only, comparator on and off
    n = 1 + ($unsigned($random(seed)) % 14);
    fd_cfg = '{32'h0000_0101, 32'h0000_010F, 32'h0000_0100 | 32'(n), 32'h0000_0005,
      32'h0000_0100, 32'h0000_010F, 32'h0000_030F};
    fd_lo = '{32, 480, 32 * n, 0, 0, 10, 480};
    fd_hi = '{32, 480, 32 * n, 0, 0, 13, 480};
    for (int i = 0; i < 7; i++) begin
      trip_en <= (i >= 5);
      fd_count(fd_cfg[i], cyc);
      `CHK("fdlen", 1'b1, cyc inside {[fd_lo[i]:fd_hi[i]]})
    end
    // run scale with random sines and load requests
    n = 16 + ($unsigned($random(seed)) % 16);
    wr(8'h04, 32'h0401_0008 | 32'(n << 8));
    repeat (8) begin
      sa = $random(seed) % 256;
      sb = $random(seed) % 256;
      sc = $unsigned($random(seed)) % 32;
      coil_a_sine <= 9'(sa);
      coil_b_sine <= 9'(sb);
      adaptive_scale <= 5'(sc);
      repeat (3) @(posedge hclk);
      sc = (sc < n) ? sc : n;
      `CHK("scale", 5'(sc), current_scale)
      `CHK("tga", 9'((sa * (sc + 1)) >>> 5), coil_a_target)
      `CHK("tgb", 9'((sb * (sc + 1)) >>> 5), coil_b_target)
    end
    adaptive_scale <= 5'h1F;
    // standstill: power-down delay, zero wait, one step per hold delay
    wr(8'h04, 32'h0101_1F1C);
    wr(8'h08, 32'h0000_0102);
    // let the new run scale reach the scale output before timing starts
    repeat (2) @(posedge hclk);
    standstill <= 1'b1;
    wait_chg(cyc);
    `CHK("t_first", 1'b1, cyc inside {[560:580]})
    `CHK("step", 5'h1E, current_scale)
    wait_chg(cyc);
    `CHK("t_step", 1'b1, cyc inside {[16:19]})
    wait_chg(cyc);
    repeat (100) @(posedge hclk);
    `CHK("hold", 5'h1C, current_scale)
    // status word: hold state, scale 28, no fast decay
    bus(1'b0, 8'h10, 32'h0000_0000);
    `CHK("stat", 32'h0000_041C, rd)
    // motion start: one step up per run delay
    standstill <= 1'b0;
    wait_chg(cyc);
    `CHK("t_up", 1'b1, cyc inside {[512:520]})
    `CHK("up", 5'h1D, current_scale)
    wait_chg(cyc);
    wait_chg(cyc);
    `CHK("run", 5'h1F, current_scale)
    // motion in mid ramp down resumes upward from there
    standstill <= 1'b1;
    wait_chg(cyc);
    standstill <= 1'b0;
    wait_chg(cyc);
    `CHK("resume", 5'h1F, current_scale)
    // zero delays: instant drop, instant rise
    wr(8'h04, 32'h0000_1F1C);
    standstill <= 1'b1;
    wait_chg(cyc);
    `CHK("drop", 5'h1C, current_scale)
    standstill <= 1'b0;
    wait_chg(cyc);
    `CHK("t_jump", 1'b1, cyc < 6)
    `CHK("jump", 5'h1F, current_scale)
    end_sim();
  end
endmodule
bind ccc_top ccc_props #(.HOLD_UNIT_CYC(HOLD_UNIT_CYC), .PD_UNIT_CYC(PD_UNIT_CYC)) props_u (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .on_phase_end, .chopper_mode_select, .fast_decay_active, .sine_offset, .current_scale,
  .coil_a_sine, .coil_a_target, .reference_current_scale, .iref_percent
);
